// ===== inc/iolp_pkg.sv
// package for the remote i/o line passing output block
// ==========================================================================
// Operation
// RQ1: digital outputs follow remote digital input states
// RQ2: analog channels 0/1 drive pulse outputs 0/1
// RQ3: forward samples to host when protocol 1/2
// RQ4: forwarding only matters with non-default address
// RQ5: forward enable is one bit, resets enabled
// RQ6: all-ones address disables line passing
// RQ7: address 0xFFFF accepts any sample source
// RQ8: accepted sample updates every configured output
// RQ9: lines 0-9 each own revert timeout
// RQ10: lines 10-14 each own revert timeout
// RQ11: shared pwm timeout zeroes both duties
// RQ12: duty values are ten bits wide
// RQ13: timeout restarts on update, 100 ms tick
package iolp_pkg;
   // ======================================================================
   // sizes
   localparam int NUM_DIG   = 15;             // digital lines 0..14
   localparam int NUM_PWM   = 2;              // pulse outputs
   localparam int ADDR_W    = 64;             // bound source address width
   localparam int TMO_W     = 13;             // fits 0x1770
   localparam int DUTY_W    = 10;             // duty 0..0x3FF
   localparam int LINE_PULSE_OUT_0 = 10;             // line carrying pulse_out_0
   localparam int LINE_PULSE_OUT_1 = 11;             // line carrying pulse_out_1
   // ======================================================================
   // register offsets (byte addresses, word index == address / 4, all multiples of four)
   localparam logic [7:0] OFS_CTRL     = 8'h00; // fwd enable, protocol
   localparam logic [7:0] OFS_ADDR_LO  = 8'h04; // bound address bits 31:0
   localparam logic [7:0] OFS_ADDR_HI  = 8'h08; // bound address bits 63:32
   localparam logic [7:0] OFS_DOUT_CFG = 8'h0C; // line is output / pwm cfg
   localparam logic [7:0] OFS_DFLT     = 8'h10; // configured revert levels
   localparam logic [7:0] OFS_PWM_TMO  = 8'h14; // shared pwm timeout
   localparam logic [7:0] OFS_STATUS   = 8'h18; // live outputs
   localparam logic [7:0] OFS_DUTY     = 8'h1C; // live duties
   localparam logic [7:0] OFS_TMO0     = 8'h40; // line n timeout at 0x40+4n
   // ======================================================================
   // field positions
   localparam int CTRL_FWD_BIT = 0;           // sample_forward_enable
   localparam int CTRL_AP_LSB  = 4;           // host_protocol_setting 4 bits
   localparam int CFG_PULSE_OUT_0_BIT = 15;          // pulse_out_0 as pwm
   localparam int CFG_PULSE_OUT_1_BIT = 16;          // pulse_out_1 as pwm
   // ======================================================================
   // reset values
   localparam logic              FWD_RST     = 1'b1;   // enabled
   localparam logic [ADDR_W-1:0] ADDR_RST    = '1;     // passing off
   localparam logic [ADDR_W-1:0] ADDR_ANY    = 64'h0000_0000_0000_FFFF;
   localparam logic [TMO_W-1:0]  TMO_RST     = 13'h0000;
   localparam logic [TMO_W-1:0]  PWM_TMO_RST = 13'h00FF;
   localparam logic [TMO_W-1:0]  TMO_MAX     = 13'h1770;
   localparam logic [3:0]        AP_API1     = 4'h1;
   localparam logic [3:0]        AP_API2     = 4'h2;
   // ======================================================================
   // timing: 100 ms tick from a 20 MHz clock
   localparam int CLK_HZ     = 20_000_000;
   localparam int TICK_MS    = 100;
   localparam int TICK_CYC   = CLK_HZ / 1000 * TICK_MS;
   // ======================================================================
   // received sample carrier
   typedef struct packed {
      logic [ADDR_W-1:0]  src;                // sender address
      logic [NUM_DIG-1:0] dig;                // reported digital states
      logic [DUTY_W-1:0]  an0;                // analog_in_0
      logic [DUTY_W-1:0]  an1;                // analog_in_1
   } iolp_sample_t;
endpackage : iolp_pkg

// ===== verilog/iolp_top.sv
// remote i/o line passing: drives local outputs from remote samples
`timescale 1ns/1ns
`default_nettype none
module iolp_top
   import iolp_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC       // cycles per 100 ms tick
) (
   // clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst,
   // register port
   input  wire logic [7:0]         reg_addr,
   input  wire logic [31:0]        reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [31:0]        reg_rdata,
   // received sample path
   input  wire logic               smp_valid,
   input  wire iolp_sample_t       smp_data,
   // host forwarding path
   output logic                    fwd_valid,
   output iolp_sample_t            fwd_data,
   // local pins
   output logic      [NUM_DIG-1:0] dig_out,
   output logic      [DUTY_W-1:0]  pulse_out_0_duty,
   output logic      [DUTY_W-1:0]  pulse_out_1_duty
);
   // ======================================================================
   // configuration registers
   // all of these are written only through the register port; timeouts
   // are clamped on the way in so that no counter chases a limit beyond
   // the legal range
   logic              fwd_en_ff;              // sample_forward_enable
   logic [3:0]        ap_ff;                  // host_protocol_setting
   logic [ADDR_W-1:0] addr_ff;                // bound_source_address
   logic [16:0]       cfg_ff;                 // output / pwm configuration
   logic [NUM_DIG-1:0] dflt_ff;               // configured revert levels
   logic [TMO_W-1:0]  pwm_tmo_ff;             // pwm_shared_timeout
   logic [TMO_W-1:0]  tmo_ff [NUM_DIG];       // per-line timeouts
   logic [31:0]       rdata_ff;               // read data register

   // ======================================================================
   // decode
   // one strobe per register; the per-line timeout strobes live in the
   // line generate below so that each line decodes its own offset
   wire wr_ctrl  = reg_wr && (reg_addr == OFS_CTRL);
   wire wr_alo   = reg_wr && (reg_addr == OFS_ADDR_LO);
   wire wr_ahi   = reg_wr && (reg_addr == OFS_ADDR_HI);
   wire wr_cfg   = reg_wr && (reg_addr == OFS_DOUT_CFG);
   wire wr_dflt  = reg_wr && (reg_addr == OFS_DFLT);
   wire wr_ptmo  = reg_wr && (reg_addr == OFS_PWM_TMO);
   wire [TMO_W-1:0] wtmo = (reg_wdata[TMO_W-1:0] > TMO_MAX) ?
                           TMO_MAX : reg_wdata[TMO_W-1:0]; // clamp range

   // ======================================================================
   // sample acceptance
   // the all-ones address is tested first because it must switch
   // passing off whatever source the sample claims
   wire pass_off   = (addr_ff == ADDR_RST);             // [RQ6]
   wire any_src    = (addr_ff == ADDR_ANY);             // [RQ7]
   wire accept     = smp_valid && !pass_off &&
                     (any_src || smp_data.src == addr_ff); // [RQ8]
   wire api_mode   = (ap_ff == AP_API1) || (ap_ff == AP_API2);
   // default address means passing is off, so forwarding is moot
   wire do_fwd     = accept && fwd_en_ff && api_mode;   // [RQ3] [RQ4]
   wire pulse_out_0_act   = cfg_ff[CFG_PULSE_OUT_0_BIT];
   wire pulse_out_1_act   = cfg_ff[CFG_PULSE_OUT_1_BIT];

   // ======================================================================
   // 100 ms tick divider
   // free-running, so the first tick after an update may come early; a
   // timeout of n lasts between n-1 and n ticks, the price of one shared
   // divider instead of one per line
   logic [31:0] div_ff;
   wire tick = (div_ff == 32'(TICK_CYCLES - 1));        // [RQ13]
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         div_ff <= 32'h0000_0000;
      end else begin
         // wrap at the end of each tick period
         div_ff <= tick ? 32'h0000_0000 : div_ff + 32'h0000_0001;
      end
   end

   // ======================================================================
   // register writes
   // writes wider than a field are cut to it; the address is written in
   // two halves and stands half-updated between them
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fwd_en_ff  <= FWD_RST;                         // [RQ5]
         ap_ff      <= 4'h0;
         addr_ff    <= ADDR_RST;
         cfg_ff     <= 17'h00000;
         dflt_ff    <= '0;
         pwm_tmo_ff <= PWM_TMO_RST;                     // [RQ11]
      end else begin
         if (wr_ctrl) begin
            fwd_en_ff <= reg_wdata[CTRL_FWD_BIT];       // [RQ5]
            ap_ff     <= reg_wdata[CTRL_AP_LSB +: 4];
         end
         if (wr_alo) addr_ff[31:0]  <= reg_wdata;
         if (wr_ahi) addr_ff[63:32] <= reg_wdata;
         if (wr_cfg) cfg_ff  <= reg_wdata[16:0];
         if (wr_dflt) dflt_ff <= reg_wdata[NUM_DIG-1:0];
         if (wr_ptmo) pwm_tmo_ff <= wtmo;
      end
   end

   // ======================================================================
   // per-line output, timeout register and revert counter
   // priority per line: a fresh sample beats expiry, expiry beats
   // counting; a line that holds no passed value shows its configured
   // level, so a default written later takes effect at once
   // a timeout of zero never expires and the line keeps its value
   logic [NUM_DIG-1:0] dout_ff;               // live line levels
   logic [NUM_DIG-1:0] held_ff;               // line holds a passed value
   genvar gi;
   generate
      for (gi = 0; gi < NUM_DIG; gi++) begin : g_line
         logic [TMO_W-1:0] cnt_ff;            // ticks since last update
         wire wr_t = reg_wr && (reg_addr == 8'(OFS_TMO0 + 4 * gi));
         wire is_out = cfg_ff[gi];
         wire expire = held_ff[gi] && (tmo_ff[gi] != TMO_RST) && tick &&
                       (cnt_ff + 13'h0001 >= tmo_ff[gi]);
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               tmo_ff[gi]  <= TMO_RST;         // [RQ9] [RQ10]
               cnt_ff      <= 13'h0000;
               dout_ff[gi] <= 1'b0;
               held_ff[gi] <= 1'b0;
            end else begin
               if (wr_t) tmo_ff[gi] <= wtmo;
               if (accept && is_out) begin
                  // same-numbered input drives this output
                  dout_ff[gi] <= smp_data.dig[gi];     // [RQ1] [RQ8]
                  held_ff[gi] <= 1'b1;
                  cnt_ff      <= 13'h0000;             // [RQ13]
               end else if (expire) begin
                  dout_ff[gi] <= dflt_ff[gi];          // [RQ9] [RQ10]
                  held_ff[gi] <= 1'b0;
                  cnt_ff      <= 13'h0000;
               end else if (held_ff[gi] && tick) begin
                  cnt_ff <= cnt_ff + 13'h0001;
               end else if (!held_ff[gi]) begin
                  dout_ff[gi] <= dflt_ff[gi];          // idle at cfg level
               end
            end
         end
      end
   endgenerate

   // ======================================================================
   // pulse duties and shared pwm timeout
   // one counter serves both outputs; it runs only after a sample has
   // updated a pulse output set up for pwm, and zero duty is the resting
   // state once it runs out
   logic [DUTY_W-1:0] duty0_ff;
   logic [DUTY_W-1:0] duty1_ff;
   logic [TMO_W-1:0]  pcnt_ff;
   logic              pheld_ff;
   // an update counts only if at least one output is set up for pwm
   wire pupd    = accept && (pulse_out_0_act || pulse_out_1_act);
   wire pexpire = pheld_ff && (pwm_tmo_ff != TMO_RST) && tick &&
                  (pcnt_ff + 13'h0001 >= pwm_tmo_ff);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         duty0_ff <= '0;
         duty1_ff <= '0;
         pcnt_ff  <= 13'h0000;
         pheld_ff <= 1'b0;
      end else if (pupd) begin
         // only channels 0 and 1 pass through, ten bits each
         if (pulse_out_0_act) duty0_ff <= smp_data.an0;       // [RQ2] [RQ12]
         if (pulse_out_1_act) duty1_ff <= smp_data.an1;       // [RQ2] [RQ12]
         pcnt_ff  <= 13'h0000;                         // [RQ13]
         pheld_ff <= 1'b1;
      end else if (pexpire) begin
         duty0_ff <= '0;                               // [RQ11]
         duty1_ff <= '0;
         pheld_ff <= 1'b0;
         pcnt_ff  <= 13'h0000;
      end else if (pheld_ff && tick) begin
         pcnt_ff <= pcnt_ff + 13'h0001;
      end
   end

   // ======================================================================
   // forwarding and read-back
   // forwarding copies the whole sample, address included, so the host
   // can tell the sender; read data is zero outside its one cycle
   iolp_sample_t fwd_ff;
   logic         fwdv_ff;
   wire [31:0] rd_mux =
      (reg_addr == OFS_CTRL)     ? {24'h0, ap_ff, 3'h0, fwd_en_ff} :
      (reg_addr == OFS_ADDR_LO)  ? addr_ff[31:0] :
      (reg_addr == OFS_ADDR_HI)  ? addr_ff[63:32] :
      (reg_addr == OFS_DOUT_CFG) ? {15'h0, cfg_ff} :
      (reg_addr == OFS_DFLT)     ? {17'h0, dflt_ff} :
      (reg_addr == OFS_PWM_TMO)  ? {19'h0, pwm_tmo_ff} :
      (reg_addr == OFS_STATUS)   ? {15'h0, pheld_ff, 1'b0, dout_ff} :
      (reg_addr == OFS_DUTY)     ? {6'h0, duty1_ff, 6'h0, duty0_ff} :
      (reg_addr >= OFS_TMO0 && reg_addr < 8'h7C && reg_addr[1:0] == 2'b00)
         ? {19'h0, tmo_ff[4'(reg_addr[5:2])]} : 32'h0000_0000;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_ff <= 32'h0000_0000;
         fwd_ff   <= '0;
         fwdv_ff  <= 1'b0;
      end else begin
         rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
         // fwd_valid is high for one cycle per forwarded sample, so back-to-back samples keep it high
         fwdv_ff  <= do_fwd;                           // [RQ3]
         if (do_fwd) fwd_ff <= smp_data;
      end
   end

   // every output comes straight from a flip-flop
   assign reg_rdata        = rdata_ff;
   assign fwd_valid        = fwdv_ff;
   assign fwd_data         = fwd_ff;
   assign dig_out          = dout_ff;
   assign pulse_out_0_duty = duty0_ff;
   assign pulse_out_1_duty = duty1_ff;

   // ======================================================================
   // checks
   // the pass-through properties (a_dig, a_an, a_an0, a_fdat) watch the registered outputs one cycle after the
   // edge that accepted a sample, which is when they must have moved
   property p_off;
      @(posedge clk_sys) disable iff (rst) pass_off |-> !accept;
   endproperty
   a_off: assert property (p_off) else $error("passing not off"); // [RQ6]
   property p_dig;
      @(posedge clk_sys) disable iff (rst)
      (accept && cfg_ff[0]) |=> dig_out[0] == $past(smp_data.dig[0]);
   endproperty
   a_dig: assert property (p_dig) else $error("line 0 not passed"); // [RQ1]
   property p_an;
      @(posedge clk_sys) disable iff (rst)
      (accept && pulse_out_1_act) |=> pulse_out_1_duty == $past(smp_data.an1);
   endproperty
   a_an: assert property (p_an) else $error("duty 1 not passed"); // [RQ2]
   property p_fwd;
      @(posedge clk_sys) disable iff (rst) fwd_valid |-> $past(api_mode);
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward bad mode"); // [RQ3]
   property p_fwd2;
      @(posedge clk_sys) disable iff (rst)
      fwd_valid |-> $past(fwd_en_ff) && !$past(pass_off);
   endproperty
   a_fwd2: assert property (p_fwd2) else $error("forward disabled"); // [RQ4]
   property p_any;
      @(posedge clk_sys) disable iff (rst)
      (any_src && smp_valid) |-> accept;
   endproperty
   a_any: assert property (p_any) else $error("any source refused"); // [RQ7]
   property p_pexp;
      @(posedge clk_sys) disable iff (rst)
      (pexpire && !pupd) |=>
         (pulse_out_0_duty == '0) && (pulse_out_1_duty == '0);
   endproperty
   a_pexp: assert property (p_pexp) else $error("pwm not zeroed"); // [RQ11]
   property p_zero;
      @(posedge clk_sys) disable iff (rst)
      (tmo_ff[0] == TMO_RST) |-> !g_line[0].expire;
   endproperty
   a_zero: assert property (p_zero) else $error("zero timeout fired"); // [RQ9]
   property p_rng;
      @(posedge clk_sys) disable iff (rst) tmo_ff[14] <= TMO_MAX;
   endproperty
   a_rng: assert property (p_rng) else $error("timeout range"); // [RQ10]
   property p_an0;
      @(posedge clk_sys) disable iff (rst)
      (accept && pulse_out_0_act) |=> pulse_out_0_duty == $past(smp_data.an0);
   endproperty
   a_an0: assert property (p_an0) else $error("duty 0 not passed"); // [RQ12]
   property p_fdat;
      @(posedge clk_sys) disable iff (rst)
      fwd_valid |-> fwd_data == $past(smp_data);
   endproperty
   a_fdat: assert property (p_fdat) else $error("forward data"); // [RQ3]
   property p_rs;
      @(posedge clk_sys) disable iff (rst)
      (accept && cfg_ff[0]) |=> g_line[0].cnt_ff == 13'h0000;
   endproperty
   a_rs: assert property (p_rs) else $error("count not reset"); // [RQ13]
   property p_rev;
      @(posedge clk_sys) disable iff (rst)
      (g_line[0].expire && !(accept && cfg_ff[0])) |=>
         dig_out[0] == $past(dflt_ff[0]);
   endproperty
   a_rev: assert property (p_rev) else $error("line 0 no revert"); // [RQ9]
   property p_rev14;
      @(posedge clk_sys) disable iff (rst)
      (g_line[14].expire && !(accept && cfg_ff[14])) |=>
         dig_out[14] == $past(dflt_ff[14]);
   endproperty
   a_rev14: assert property (p_rev14) else $error("line 14 revert"); // [RQ10]
   property p_pkeep;
      @(posedge clk_sys) disable iff (rst)
      (pwm_tmo_ff == TMO_RST && !pupd) |=>
         $stable(pulse_out_0_duty) && $stable(pulse_out_1_duty);
   endproperty
   a_pkeep: assert property (p_pkeep) else $error("duty lost"); // [RQ11]
   c_acc: cover property (@(posedge clk_sys) accept);
   c_fwd: cover property (@(posedge clk_sys) fwd_valid);
   c_exp: cover property (@(posedge clk_sys) pexpire);
   c_rev: cover property (@(posedge clk_sys) g_line[0].expire);
   c_any: cover property (@(posedge clk_sys) any_src && accept);
endmodule : iolp_top
`default_nettype wire

// ===== test/iolp_node_model.sv
// remote node model that emits i/o sample packets toward the block
`timescale 1ns/1ns
`default_nettype none
module iolp_node_model
   import iolp_pkg::*;
(
   // clock
   input  wire logic    clk_sys,
   // sample path toward the block
   output logic         smp_valid,
   output iolp_sample_t smp_data
);
   // ======================================================================
   // idle state: nothing offered
   initial begin
      smp_valid = 1'b0;
      smp_data  = '0;
   end
   // one sample, valid for exactly one cycle after a rising edge
   task automatic send(input logic [63:0] src, input logic [14:0] dig,
                       input logic [9:0] an0, input logic [9:0] an1);
      @(posedge clk_sys);
      smp_valid <= 1'b1;
      smp_data  <= '{src, dig, an0, an1};
      @(posedge clk_sys);
      smp_valid <= 1'b0;
      // scramble stale data so a late capture cannot look correct
      smp_data  <= ~smp_data;
   endtask : send
endmodule : iolp_node_model
`default_nettype wire

// ===== test/iolp_top_test.sv
// self-checking testbench for the remote i/o line passing block
`timescale 1ns/1ns
`default_nettype none
module iolp_top_test
   import iolp_pkg::*;
;
   // ======================================================================
   // signals
   localparam int TK = 10;                    // short tick for simulation
   logic         clk_sys, rst;                // clock and reset
   logic [7:0]   reg_addr;                    // register port
   logic [31:0]  reg_wdata, reg_rdata;
   logic         reg_wr, reg_rd;
   logic         smp_valid, fwd_valid;        // sample paths
   iolp_sample_t smp_data, fwd_data;
   logic [14:0]  dig_out;                     // local pins
   logic [9:0]   duty0, duty1;
   int           mismatches, cmp_count;       // verdict counters
   // ======================================================================
   // design, remote node
   iolp_top #(.TICK_CYCLES(TK)) dut_u (
      .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .smp_valid(smp_valid), .smp_data(smp_data),
      .fwd_valid(fwd_valid), .fwd_data(fwd_data), .dig_out(dig_out),
      .pulse_out_0_duty(duty0), .pulse_out_1_duty(duty1));
   iolp_node_model node_u (
      .clk_sys(clk_sys), .smp_valid(smp_valid), .smp_data(smp_data));
   // 20 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // ======================================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask : wr
   // read strobe, data stands only in the following cycle
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rdchk
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : wait_cyc
   // ======================================================================
   // scenarios
   task automatic t_reset;
      rdchk(OFS_CTRL, 32'h0000_0001);
      rdchk(OFS_PWM_TMO, 32'h0000_00FF);
      rdchk(OFS_ADDR_LO, 32'hFFFF_FFFF);
      rdchk(OFS_TMO0, 32'h0000_0000);
      rdchk(8'h78, 32'h0000_0000);
      rdchk(8'h3C, 32'h0000_0000);
   endtask : t_reset
   // default address: samples must not reach pins or host
   task automatic t_disabled;
      wr(OFS_CTRL, 32'h0000_0011);
      wr(OFS_DOUT_CFG, 32'h0001_FFFF);
      node_u.send(64'h1234, 15'h7FFF, 10'h3FF, 10'h3FF);
      #1 chk(32'(dig_out), 32'h0);
      chk(32'(fwd_valid), 32'h0);
      chk(32'(duty0 | duty1), 32'h0);
   endtask : t_disabled
   // bound address, foreign source ignored, forwarding table
   task automatic t_pass;
      int i;
      wr(OFS_ADDR_LO, 32'h0000_1234);
      wr(OFS_ADDR_HI, 32'h0000_0000);
      node_u.send(64'h1235, 15'h7FFF, 10'h3FF, 10'h3FF);
      #1 chk(32'(dig_out), 32'h0);
      node_u.send(64'h1234, 15'h5A5A, 10'h3FF, 10'h155);
      #1 chk(32'(dig_out), 32'h5A5A);
      chk(32'(duty0), 32'h3FF);
      chk(32'(duty1), 32'h155);
      chk(32'(fwd_data.dig), 32'h5A5A);
      chk(fwd_data.src[31:0], 32'h0000_1234);
      for (i = 0; i < 5; i++) begin
         // i<4: enabled with protocol i; i=4: disabled, protocol 1
         wr(OFS_CTRL, (i < 4) ? (32'(i) << 4) | 32'h1 : 32'h10);
         node_u.send(64'h1234, 15'h0001, 10'h001, 10'h002);
         #1 chk(32'(fwd_valid), 32'(i == 1 || i == 2));
      end
      rdchk(OFS_CTRL, 32'h0000_0010);
   endtask : t_pass
   // wildcard address takes any source
   task automatic t_any;
      wr(OFS_ADDR_LO, 32'h0000_FFFF);
      node_u.send(64'hDEAD_BEEF_0000_0042, 15'h4421, 10'h0, 10'h0);
      #1 chk(32'(dig_out), 32'h4421);
   endtask : t_any
   // per-line revert, restart on update, shared pwm revert
   task automatic t_timeout;
      wr(8'h44, 32'h0000_1FFF);
      rdchk(8'h44, 32'h0000_1770);
      wr(OFS_TMO0, 32'h2);
      wr(8'h70, 32'h3);
      wr(OFS_PWM_TMO, 32'h1);
      node_u.send(64'h7, 15'h7FFF, 10'h200, 10'h100);
      wait_cyc(8);
      chk(32'(dig_out[0]), 32'h1);
      wait_cyc(4);
      node_u.send(64'h7, 15'h7FFF, 10'h200, 10'h100);
      wait_cyc(9);
      chk(32'(dig_out[0]), 32'h1);
      wait_cyc(14);
      chk(32'(dig_out[0]), 32'h0);
      chk(32'(duty0 | duty1), 32'h0);
      wait_cyc(10);
      chk(32'(dig_out[12]), 32'h0);
      chk(32'(dig_out[14]), 32'h1);
      // line 0 no longer holds a value, so it shows the new default
      wr(OFS_DFLT, 32'h0000_0001);
      rdchk(OFS_STATUS, 32'h0000_6FFF);
      rdchk(OFS_DUTY, 32'h0000_0000);
   endtask : t_timeout
   // ======================================================================
   // verdict, called once from the main flow or the watchdog
   task automatic give_verdict;
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   // main sequence
   initial begin
      mismatches = 0;
      cmp_count  = 0;
      rst        = 1'b1;
      reg_addr   = 8'h00;
      reg_wdata  = 32'h0;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset();
      t_disabled();
      t_pass();
      t_any();
      t_timeout();
      give_verdict();
   end
   // watchdog: tests need well under a thousand cycles
   initial begin
      #(50 * 20000);
      mismatches++;
      give_verdict();
   end
endmodule : iolp_top_test
`default_nettype wire
